// file: hw/rtc_pkg.sv
// Shared constants for the BCD real-time clock and its two-wire host
package rtc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Two-wire addressing
	localparam logic [6:0]  SLAVE_ADDR    = 7'h68;
	localparam logic [5:0]  REG_SEC       = 6'h00;
	localparam logic [5:0]  REG_MIN       = 6'h01;
	localparam logic [5:0]  REG_HOUR      = 6'h02;
	localparam logic [5:0]  REG_WDAY      = 6'h03;
	localparam logic [5:0]  REG_DATE      = 6'h04;
	localparam logic [5:0]  REG_MON       = 6'h05;
	localparam logic [5:0]  REG_YEAR      = 6'h06;
	localparam logic [5:0]  REG_CTRL      = 6'h07;
	localparam logic [5:0]  RAM_FIRST     = 6'h08;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int          SEC_HALT_BIT  = 7;
	localparam int          HOUR_CEB_BIT  = 7;
	localparam int          HOUR_CB_BIT   = 6;
	localparam int          CTRL_OUT_BIT  = 7;
	localparam int          CTRL_FT_BIT   = 6;
	localparam int          CTRL_SIGN_BIT = 5;
	localparam logic [7:0]  CTRL_RESET    = 8'hA0;
	localparam logic [7:0]  SEC_RESET     = 8'h00;
	localparam logic [7:0]  MIN_RESET     = 8'h00;
	localparam logic [7:0]  HOUR_RESET    = 8'h00;
	localparam logic [2:0]  WDAY_RESET    = 3'h1;
	localparam logic [7:0]  DATE_RESET    = 8'h01;
	localparam logic [7:0]  MON_RESET     = 8'h01;
	localparam logic [7:0]  YEAR_RESET    = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int          CLK_HZ        = 25_000_000;
	localparam int          OSC_HZ        = 32_768;
	localparam int          OSC_DIV       = CLK_HZ / OSC_HZ;
	localparam logic [15:0] SEC_TICKS     = 16'h8000;
	localparam logic [15:0] CAL_SHORT     = 16'h0080;
	localparam logic [15:0] CAL_LONG      = 16'h0100;
	localparam logic [5:0]  CAL_ADJ_MIN   = 6'h3E;
	localparam logic [4:0]  SQ_HALF_LAST  = 5'h1F;
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          SCL_PERIOD_NS = 2500;
	localparam int          SCL_QUARTER   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Host controller APB map
	localparam logic [11:0] HOST_CMD      = 12'h000;
	localparam logic [11:0] HOST_TX       = 12'h004;
	localparam logic [11:0] HOST_RX       = 12'h008;
	localparam logic [11:0] HOST_STATUS   = 12'h00C;
	localparam int          CMD_GO_BIT    = 0;
	localparam int          CMD_START_BIT = 1;
	localparam int          CMD_STOP_BIT  = 2;
	localparam int          CMD_READ_BIT  = 3;
	localparam int          CMD_NACK_BIT  = 4;

endpackage

// file: hw/rtc_i2c_if.sv
// Open-drain two-wire bus joining the host and the clock device
`timescale 1ns/1ps
interface rtc_i2c_if;
	logic m_scl_oe;
	logic m_sda_oe;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up: any enable pulls the line low
	assign scl = ~m_scl_oe;
	assign sda = ~(m_sda_oe | s_sda_oe);

	modport host (output m_scl_oe, output m_sda_oe, input scl, input sda);
	modport dev  (output s_sda_oe, input scl, input sda);
endinterface

// file: hw/rtc_dev.sv
// BCD clock and calendar with calibration, level/test pin and two-wire slave
// Notes on behaviour
// [R1] Test bit clear: pin follows level bit
// [R2] Test bit set: 512Hz square on pin
// [R3] Calibration repeats every 64 counted minutes
// [R4] Only first 62 minutes; one second adjusted
// [R5] Magnitude N adjusts first 2N minutes
// [R6] Sign selects faster or slower step size
// [R7] Seconds 00-59 BCD, carry to minutes
// [R8] Minutes 00-59 BCD, carry to hours
// [R9] Hours 00-23, carry to date and weekday
// [R10] Halt bit stops oscillator and count chain
// [R11] Weekday counts 1 through 7, wraps
// [R12] Software maps weekdays in sequence
// [R13] Host writes only legal time values
// [R14] Date wraps at month length, leap aware
// [R15] Month 1-12, carry to year
// [R16] Year 00-99, multiples of four leap
// [R17] All counters packed BCD, tens high
// [R18] Idle lines high; start, stop by SDA
// [R19] SDA changes low, sampled high
// [R20] Respond only on own slave address
// [R21] Lines only pulled low or released
// [R22] Square wave overrides level bit
// [R23] Writes load counters, reads show count
`timescale 1ns/1ps
module rtc_dev #(
	parameter int OSC_DIV = rtc_pkg::OSC_DIV
) (
	input  wire logic pclk,
	input  wire logic presetn,
	rtc_i2c_if.dev    bus,
	output logic      pin_low_oe
);

	typedef enum {
		rtc_s_idle, rtc_s_addr, rtc_s_ack_addr, rtc_s_ptr,
		rtc_s_ack_wr, rtc_s_wdata, rtc_s_rdata, rtc_s_mack
	} rtc_slv_t;

	logic [1:0]  scl_s;
	logic [1:0]  sda_s;
	logic        scl_q;
	logic        sda_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic [15:0] div_cnt;
	logic        osc_tick;
	logic [15:0] sub_cnt;
	logic [15:0] sec_limit;
	logic        cal_adj;
	logic        sec_tick;
	logic [5:0]  cal_min;
	logic [4:0]  sq_cnt;
	logic        sq_wave;
	logic [7:0]  sec;
	logic [7:0]  min;
	logic [7:0]  hour;
	logic [2:0]  wday;
	logic [7:0]  date;
	logic [7:0]  mon;
	logic [7:0]  year;
	logic [7:0]  ctrl;
	logic        halt;
	logic        ceb;
	logic        cb;
	logic [8:0]  s_step;
	logic [8:0]  m_step;
	logic [8:0]  h_step;
	logic [8:0]  d_step;
	logic [8:0]  mo_step;
	logic [8:0]  y_step;
	logic [2:0]  w_next;
	logic [7:0]  ram [8:63];
	logic [7:0]  rd_data;
	rtc_slv_t    state;
	logic [3:0]  cnt;
	logic [7:0]  shift;
	logic [7:0]  tx;
	logic [5:0]  ptr;
	logic        rw;
	logic        mack_ok;
	logic        sda_oe;
	logic        wr_stb;
	logic [5:0]  wr_addr;
	logic [7:0]  wr_data;

	// Returns {wrap, next}
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		if (v == last)
			bcd_step = {1'b1, first};
		else if (v[3:0] == 4'h9)
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcd_step = {1'b0, v + 8'h01};
	endfunction

	function automatic logic is_leap(input logic [7:0] y);
		if (y[4])
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		else
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
	endfunction

	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		case (m)
			8'h02:                      month_last = is_leap(y) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
			default:                    month_last = 8'h31;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus line synchronisers and condition detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], bus.scl};
			sda_s <= {sda_s[0], bus.sda};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end

	assign scl_rise  = scl_s[1] & ~scl_q;  // R19
	assign scl_fall  = ~scl_s[1] & scl_q;
	assign bus_start = scl_s[1] & scl_q & sda_q & ~sda_s[1];  // R18
	assign bus_stop  = scl_s[1] & scl_q & ~sda_q & sda_s[1];  // R18

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator tick, frozen while halted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt  <= 16'h0000;
			osc_tick <= 1'b0;
		end else if (halt) begin  // R10
			div_cnt  <= 16'h0000;
			osc_tick <= 1'b0;
		end else if (div_cnt == 16'(OSC_DIV - 1)) begin
			div_cnt  <= 16'h0000;
			osc_tick <= 1'b1;
		end else begin
			div_cnt  <= div_cnt + 16'h0001;
			osc_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Second length with calibration
	assign cal_adj   = (sec == 8'h00) && (cal_min < {ctrl[4:0], 1'b0})  // R5
		&& (cal_min < rtc_pkg::CAL_ADJ_MIN);  // R4
	assign sec_limit = !cal_adj ? rtc_pkg::SEC_TICKS :
		ctrl[rtc_pkg::CTRL_SIGN_BIT] ? rtc_pkg::SEC_TICKS + rtc_pkg::CAL_LONG :  // R6
		rtc_pkg::SEC_TICKS - rtc_pkg::CAL_SHORT;  // R4
	assign sec_tick  = osc_tick && (sub_cnt == sec_limit - 16'h0001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sub_cnt <= 16'h0000;
		else if (wr_stb && wr_addr == rtc_pkg::REG_SEC)
			sub_cnt <= 16'h0000;
		else if (osc_tick)
			sub_cnt <= sec_tick ? 16'h0000 : sub_cnt + 16'h0001;
	end

	// Position in the 64-minute calibration cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cal_min <= 6'h00;
		else if (sec_tick && s_step[8])
			cal_min <= cal_min + 6'h01;  // R3
	end

	////////////////////////////////////////////////////////////////////////////////
	// Calendar chain
	always_comb begin
		s_step  = bcd_step(sec, 8'h59, 8'h00);  // R7
		m_step  = bcd_step(min, 8'h59, 8'h00);  // R8
		h_step  = bcd_step(hour, 8'h23, 8'h00);  // R9
		d_step  = bcd_step(date, month_last(mon, year), 8'h01);  // R14
		mo_step = bcd_step(mon, 8'h12, 8'h01);  // R15
		y_step  = bcd_step(year, 8'h99, 8'h00);  // R16
		w_next  = (wday == 3'h7) ? 3'h1 : wday + 3'h1;  // R11
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec  <= rtc_pkg::SEC_RESET;
			min  <= rtc_pkg::MIN_RESET;
			hour <= rtc_pkg::HOUR_RESET;
			wday <= rtc_pkg::WDAY_RESET;
			date <= rtc_pkg::DATE_RESET;
			mon  <= rtc_pkg::MON_RESET;
			year <= rtc_pkg::YEAR_RESET;
			ctrl <= rtc_pkg::CTRL_RESET;
			halt <= 1'b0;
			ceb  <= 1'b0;
			cb   <= 1'b0;
		end else if (wr_stb) begin  // R23
			case (wr_addr)
				rtc_pkg::REG_SEC: begin
					halt <= wr_data[rtc_pkg::SEC_HALT_BIT];  // R10
					sec  <= {1'b0, wr_data[6:0]};
				end
				rtc_pkg::REG_MIN:  min  <= {1'b0, wr_data[6:0]};
				rtc_pkg::REG_HOUR: begin
					ceb  <= wr_data[rtc_pkg::HOUR_CEB_BIT];
					cb   <= wr_data[rtc_pkg::HOUR_CB_BIT];
					hour <= {2'b00, wr_data[5:0]};
				end
				rtc_pkg::REG_WDAY: wday <= wr_data[2:0];
				rtc_pkg::REG_DATE: date <= {2'b00, wr_data[5:0]};
				rtc_pkg::REG_MON:  mon  <= {3'b000, wr_data[4:0]};
				rtc_pkg::REG_YEAR: year <= wr_data;
				rtc_pkg::REG_CTRL: ctrl <= wr_data;
				default: ;
			endcase
		end else if (sec_tick) begin
			sec <= s_step[7:0];  // R7
			if (s_step[8]) begin
				min <= m_step[7:0];  // R8
				if (m_step[8]) begin
					hour <= h_step[7:0];
					if (h_step[8]) begin  // R9
						wday <= w_next;
						date <= d_step[7:0];
						if (d_step[8]) begin
							mon <= mo_step[7:0];  // R15
							if (mo_step[8]) begin
								year <= y_step[7:0];
								if (y_step[8] && ceb)
									cb <= ~cb;
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_stb && wr_addr >= rtc_pkg::RAM_FIRST)
			ram[wr_addr] <= wr_data;
	end

	// Packed BCD read view
	always_comb begin
		case (ptr)
			rtc_pkg::REG_SEC:  rd_data = {halt, sec[6:0]};  // R17
			rtc_pkg::REG_MIN:  rd_data = {1'b0, min[6:0]};
			rtc_pkg::REG_HOUR: rd_data = {ceb, cb, hour[5:0]};
			rtc_pkg::REG_WDAY: rd_data = {5'h00, wday};
			rtc_pkg::REG_DATE: rd_data = {2'b00, date[5:0]};
			rtc_pkg::REG_MON:  rd_data = {3'b000, mon[4:0]};
			rtc_pkg::REG_YEAR: rd_data = year;
			rtc_pkg::REG_CTRL: rd_data = ctrl;
			default:           rd_data = ram[ptr];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test/level pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_cnt  <= 5'h00;
			sq_wave <= 1'b0;
		end else if (osc_tick) begin
			sq_cnt <= sq_cnt + 5'h01;
			if (sq_cnt == rtc_pkg::SQ_HALF_LAST)
				sq_wave <= ~sq_wave;  // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_low_oe <= 1'b0;
		else if (ctrl[rtc_pkg::CTRL_FT_BIT])
			pin_low_oe <= ~sq_wave;  // R22
		else
			pin_low_oe <= ~ctrl[rtc_pkg::CTRL_OUT_BIT];  // R1
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-wire slave
	assign bus.s_sda_oe = sda_oe;  // R21

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= rtc_s_idle;
			cnt     <= 4'h0;
			shift   <= 8'h00;
			tx      <= 8'h00;
			ptr     <= 6'h00;
			rw      <= 1'b0;
			mack_ok <= 1'b0;
			sda_oe  <= 1'b0;
			wr_stb  <= 1'b0;
			wr_addr <= 6'h00;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (bus_start) begin  // R18
				state  <= rtc_s_addr;
				cnt    <= 4'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state  <= rtc_s_idle;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin  // R19
				shift <= {shift[6:0], sda_s[1]};
				cnt   <= cnt + 4'h1;
				if (state == rtc_s_mack)
					mack_ok <= ~sda_s[1];
			end else if (scl_fall) begin  // R19
				unique case (state)
					rtc_s_idle: ;
					rtc_s_addr: if (cnt == 4'h8) begin
						if (shift[7:1] == rtc_pkg::SLAVE_ADDR) begin  // R20
							sda_oe <= 1'b1;
							rw     <= shift[0];
							state  <= rtc_s_ack_addr;
						end else
							state <= rtc_s_idle;
					end
					rtc_s_ack_addr: begin
						cnt <= 4'h0;
						if (rw) begin
							tx     <= rd_data;  // R23
							sda_oe <= ~rd_data[7];
							state  <= rtc_s_rdata;
						end else begin
							sda_oe <= 1'b0;
							state  <= rtc_s_ptr;
						end
					end
					rtc_s_ptr: if (cnt == 4'h8) begin
						ptr    <= shift[5:0];
						sda_oe <= 1'b1;
						state  <= rtc_s_ack_wr;
					end
					rtc_s_wdata: if (cnt == 4'h8) begin
						wr_stb  <= 1'b1;
						wr_addr <= ptr;
						wr_data <= shift;
						ptr     <= ptr + 6'h01;
						sda_oe  <= 1'b1;
						state   <= rtc_s_ack_wr;
					end
					rtc_s_ack_wr: begin
						sda_oe <= 1'b0;
						cnt    <= 4'h0;
						state  <= rtc_s_wdata;
					end
					rtc_s_rdata: if (cnt == 4'h8) begin
						sda_oe <= 1'b0;
						ptr    <= ptr + 6'h01;
						state  <= rtc_s_mack;
					end else
						sda_oe <= ~tx[~cnt[2:0]];
					rtc_s_mack: if (mack_ok) begin
						tx     <= rd_data;
						sda_oe <= ~rd_data[7];
						cnt    <= 4'h0;
						state  <= rtc_s_rdata;
					end else
						state <= rtc_s_idle;
				endcase
			end
		end
	end

endmodule // rtc_dev

// file: hw/rtc_host.sv
// Two-wire bus master with an APB command port
`timescale 1ns/1ps
module rtc_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	rtc_i2c_if.host          bus
);

	typedef enum {rtc_h_idle, rtc_h_start, rtc_h_bits, rtc_h_stop} rtc_host_st_t;

	rtc_host_st_t state;
	logic [1:0]   ph;
	logic [3:0]   bitn;
	logic [4:0]   qcnt;
	logic         qtick;
	logic [1:0]   sda_s;
	logic         scl_oe;
	logic         sda_oe;
	logic         f_start;
	logic         f_stop;
	logic         f_read;
	logic         f_nack;
	logic [7:0]   tx;
	logic [7:0]   rx;
	logic         acked;
	logic         wr_acc;
	logic         mapped;

	assign bus.m_scl_oe = scl_oe;  // R21
	assign bus.m_sda_oe = sda_oe;  // R21
	assign qtick        = (state != rtc_h_idle) && (qcnt == 5'h00);
	assign wr_acc       = psel && penable && pready && pwrite;
	assign mapped       = (paddr == rtc_pkg::HOST_CMD) || (paddr == rtc_pkg::HOST_TX)
		|| (paddr == rtc_pkg::HOST_RX) || (paddr == rtc_pkg::HOST_STATUS);

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, data valid with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready) begin
				case (paddr)
					rtc_pkg::HOST_CMD:    prdata <= {27'h0, f_nack, f_read, f_stop, f_start, 1'b0};
					rtc_pkg::HOST_TX:     prdata <= {24'h0, tx};
					rtc_pkg::HOST_RX:     prdata <= {24'h0, rx};
					rtc_pkg::HOST_STATUS: prdata <= {30'h0, acked, state != rtc_h_idle};
					default:              prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quarter-period divider and data synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qcnt  <= 5'(rtc_pkg::SCL_QUARTER - 1);
			sda_s <= 2'h3;
		end else begin
			sda_s <= {sda_s[0], bus.sda};
			if (state == rtc_h_idle || qcnt == 5'h00)
				qcnt <= 5'(rtc_pkg::SCL_QUARTER - 1);
			else
				qcnt <= qcnt - 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= rtc_h_idle;
			ph      <= 2'h0;
			bitn    <= 4'h0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
			f_start <= 1'b0;
			f_stop  <= 1'b0;
			f_read  <= 1'b0;
			f_nack  <= 1'b0;
			tx      <= 8'h00;
			rx      <= 8'h00;
			acked   <= 1'b0;
		end else if (state == rtc_h_idle) begin
			if (wr_acc && paddr == rtc_pkg::HOST_TX)
				tx <= pwdata[7:0];
			if (wr_acc && paddr == rtc_pkg::HOST_CMD && pwdata[rtc_pkg::CMD_GO_BIT]) begin
				f_start <= pwdata[rtc_pkg::CMD_START_BIT];
				f_stop  <= pwdata[rtc_pkg::CMD_STOP_BIT];
				f_read  <= pwdata[rtc_pkg::CMD_READ_BIT];
				f_nack  <= pwdata[rtc_pkg::CMD_NACK_BIT];
				ph      <= 2'h0;
				bitn    <= 4'h0;
				state   <= pwdata[rtc_pkg::CMD_START_BIT] ? rtc_h_start : rtc_h_bits;
			end
		end else if (qtick) begin
			ph <= ph + 2'h1;
			unique case (state)
				rtc_h_start: begin  // R18
					unique case (ph)
						2'h0: sda_oe <= 1'b0;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b1;
						2'h3: begin
							scl_oe <= 1'b1;
							state  <= rtc_h_bits;
						end
					endcase
				end
				rtc_h_bits: begin  // R19
					unique case (ph)
						2'h0: begin
							if (bitn == 4'h8)
								sda_oe <= f_read && !f_nack;
							else
								sda_oe <= !f_read && !tx[~bitn[2:0]];
						end
						2'h1: scl_oe <= 1'b0;
						2'h2: begin
							if (bitn == 4'h8) begin
								if (!f_read)
									acked <= !sda_s[1];
							end else if (f_read)
								rx <= {rx[6:0], sda_s[1]};
						end
						2'h3: begin
							scl_oe <= 1'b1;
							if (bitn == 4'h8) begin
								bitn  <= 4'h0;
								state <= f_stop ? rtc_h_stop : rtc_h_idle;
							end else
								bitn <= bitn + 4'h1;
						end
					endcase
				end
				rtc_h_stop: begin  // R18
					unique case (ph)
						2'h0: sda_oe <= 1'b1;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b0;
						2'h3: state  <= rtc_h_idle;
					endcase
				end
				rtc_h_idle: ;
			endcase
		end
	end

endmodule // rtc_host

// file: tb/rtc_chk.sv
// Wire-level checker for the two-wire link between host and clock device
`timescale 1ns/1ps
module rtc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] fall_cnt;
	logic       acked;
	logic       idle;
	wire        start_c = scl && scl_q && sda_q && !sda;
	wire        stop_c  = scl && scl_q && !sda_q && sda;

	////////////////////////////////////////////////////////////
	// Helper state: line history, clock falls since start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fall_cnt <= 4'h0;
			acked    <= 1'b0;
			idle     <= 1'b1;
		end else if (start_c) begin
			fall_cnt <= 4'h0;
			acked    <= 1'b0;
			idle     <= 1'b0;
		end else begin
			if (scl_q && !scl && fall_cnt != 4'hF)
				fall_cnt <= fall_cnt + 4'h1;
			if (s_sda_oe)
				acked <= 1'b1;
			if (stop_c)
				idle <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stop;
		stop_c;
	endsequence
	sequence s_low_till_rise;
		s_sda_oe throughout (##[1:60] $rose(scl));
	endsequence

	a_rel_after_reset: assert property ($rose(presetn) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe)
		else $error("line driven right after reset");
	a_dev_edge_low: assert property ($changed(s_sda_oe) |-> !scl && !scl_q)
		else $error("device changed data while clock high");
	a_dev_holds_bit: assert property ($rose(s_sda_oe) |-> s_low_till_rise)
		else $error("device data not held to clock rise");
	a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
		else $error("clock high phase too short");
	a_ack_ninth: assert property ($rose(s_sda_oe) && !acked |-> fall_cnt == 4'h9)
		else $error("address ack not on ninth clock");
	a_quiet_idle: assert property (idle |-> !s_sda_oe)
		else $error("device drives data outside a frame");
	a_stop_idle: assert property (s_stop |=> (scl && sda) [*8])
		else $error("lines not idle high after stop");
endmodule // rtc_chk

// file: tb/bcd_rtc_calendar_i2c_test.sv
// Self-checking bench: APB host talks to the clock device over the link
`timescale 1ns/1ps
module bcd_rtc_calendar_i2c_test;
	localparam logic [7:0] C_ST = 8'h02;
	localparam logic [7:0] C_SP = 8'h04;
	localparam logic [7:0] C_RD = 8'h08;
	localparam logic [7:0] C_NK = 8'h10;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin_low_oe;
	logic [31:0] rd;
	logic        err;
	logic        ack;
	logic [7:0]  wb [8];
	logic [7:0]  got [8];
	int          fails;
	int          cmp_count;

	rtc_i2c_if bus ();
	rtc_dev #(.OSC_DIV(2)) u_rtc_dev (.pclk(pclk), .presetn(presetn), .bus(bus),
		.pin_low_oe(pin_low_oe));
	rtc_host u_rtc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(bus));
	rtc_chk u_rtc_chk (.pclk(pclk), .presetn(presetn), .m_scl_oe(bus.m_scl_oe),
		.m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Mismatches %0d, compares %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// One byte on the wire, then wait for the host to go idle
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] tx);
		apb(1'b1, rtc_pkg::HOST_TX, {24'h0, tx});
		apb(1'b1, rtc_pkg::HOST_CMD, {24'h0, cmd | 8'h01});
		do apb(1'b0, rtc_pkg::HOST_STATUS, 32'h0); while (rd[0] !== 1'b0);
		ack = rd[1];
		apb(1'b0, rtc_pkg::HOST_RX, 32'h0);
	endtask

	task automatic dev_wr(input logic [5:0] ptr, input int n);
		xfer(C_ST, {rtc_pkg::SLAVE_ADDR, 1'b0});
		chk({7'h0, ack}, 8'h01);
		xfer(8'h00, {2'b00, ptr});
		for (int i = 0; i < n; i++)
			xfer((i == n - 1) ? C_SP : 8'h00, wb[i]);
	endtask

	task automatic dev_rd(input logic [5:0] ptr, input int n);
		xfer(C_ST, {rtc_pkg::SLAVE_ADDR, 1'b0});
		xfer(8'h00, {2'b00, ptr});
		xfer(C_ST, {rtc_pkg::SLAVE_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			xfer((i == n - 1) ? (C_RD | C_NK | C_SP) : C_RD, 8'h00);
			got[i] = rd[7:0];
		end
	endtask

	////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({7'h0, pin_low_oe}, 8'h00);
		dev_rd(6'h07, 1);
		chk(got[0], 8'hA0);
	endtask

	task automatic t_refused();
		apb(1'b0, 12'h010, 32'h0);
		chk({7'h0, err}, 8'h01);
		xfer(C_ST | C_SP, 8'hA0);
		chk({7'h0, ack}, 8'h00);
	endtask

	// Pin transitions over ten half-periods of the test wave
	task automatic count_edges(output int edges);
		logic prev;
		edges = 0;
		prev = pin_low_oe;
		repeat (640) begin
			@(posedge pclk);
			if (pin_low_oe !== prev)
				edges++;
			prev = pin_low_oe;
		end
	endtask

	task automatic t_pin();
		int edges;
		wb[0] = 8'h20;
		dev_wr(6'h07, 1);
		chk({7'h0, pin_low_oe}, 8'h01);
		wb[0] = 8'h60;
		dev_wr(6'h07, 1);
		count_edges(edges);
		chk(8'(edges), 8'h0A);
		wb[0] = 8'h80;
		dev_wr(6'h00, 1);
		count_edges(edges);
		chk(8'(edges), 8'h00);
		dev_rd(6'h00, 1);
		chk(got[0], 8'h80);
		wb[0] = 8'hA0;
		dev_wr(6'h07, 1);
		chk({7'h0, pin_low_oe}, 8'h00);
	endtask

	// Last second of a leap February 28th, Saturday-like day 7
	task automatic t_rollover();
		logic [7:0] exp [8];
		wb = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h04, 8'h00};
		exp = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04, 8'h00};
		dev_wr(6'h00, 7);
		// Tick lands well before the seconds byte is fetched, far from the next one
		repeat (61500) @(posedge pclk);
		dev_rd(6'h00, 7);
		for (int i = 0; i < 7; i++)
			chk(got[i], exp[i]);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fails = 0;
		cmp_count = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_refused();
		t_pin();
		t_rollover();
		print_verdict();
	end

	initial begin
		repeat (98000) @(posedge pclk);
		fails++;
		print_verdict();
	end
endmodule // bcd_rtc_calendar_i2c_test
